//--- hdl/xlt_defines.svh
/*
 * constants of the address translator: timing figures, derived cycle counts,
 * field positions and reset values.
 * assumes the reference clock at 50 MHz and the link clock at 12 ns period.
 */
`ifndef XLT_DEFINES_SVH
`define XLT_DEFINES_SVH

// clock periods
`define XLT_REF_PERIOD_NS 20
`define XLT_LINK_PERIOD_NS 12

// timing figures in their own units
`define XLT_IDLE_TIME_US 120
`define XLT_STUCK_TIME_MS 30
`define XLT_XLATE_DELAY_NS 100
`define XLT_STOPGEN_DELAY_NS 1000

// derived cycle counts: least times round up, approximate delay rounds down
`define XLT_IDLE_CYCLES ((`XLT_IDLE_TIME_US * 1000 + `XLT_REF_PERIOD_NS - 1) / `XLT_REF_PERIOD_NS)
`define XLT_STUCK_CYCLES ((`XLT_STUCK_TIME_MS * 1000000 + `XLT_LINK_PERIOD_NS - 1) / `XLT_LINK_PERIOD_NS)
`define XLT_XLATE_CYCLES (`XLT_XLATE_DELAY_NS / `XLT_LINK_PERIOD_NS)
`define XLT_STOPGEN_CYCLES ((`XLT_STOPGEN_DELAY_NS + `XLT_LINK_PERIOD_NS - 1) / `XLT_LINK_PERIOD_NS)

// translation byte layout
`define XLT_LOW_CFG_LSB 0
`define XLT_HIGH_CFG_LSB 4
`define XLT_ADDR_BITS 7
`define XLT_RW_FALL 8
`define XLT_DATA_FALL 9
`define XLT_XLATE_RESET 7'h00

`endif

//--- hdl/xlt_pkg.sv
/*
 * types of the address translator: state enumerations of both clock domains.
 * assumes nothing of its surroundings.
 */
package xlt_pkg;

    // control side, reference clock
    typedef enum logic [1:0] {
        CTL_OFF,
        CTL_LOAD,
        CTL_WAIT_IDLE,
        CTL_ON
    } xlt_ctl_state_t;

    // bus side, link clock
    typedef enum logic [2:0] {
        LNK_IDLE,
        LNK_ADDR,
        LNK_DATA,
        LNK_WAIT_STOP,
        LNK_STOP_GEN
    } xlt_link_state_t;

endpackage : xlt_pkg

//--- hdl/xlt_translator.sv
/*
 * inline two-wire address translator: control side on REF_CLK (enable, load
 * of the translation byte, connection and ready), bus side on LINK_CLK
 * (start/stop detection, xor of the address bits, stop generation, timeout).
 * assumes decoded configuration levels, open-drain bus lines resolved outside,
 * and a free-running LINK_CLK.
 */
`timescale 1ns/1ps
`include "xlt_defines.svh"

module xlt_translator #(
    parameter int unsigned IDLE_CYCLES = `XLT_IDLE_CYCLES,
    parameter int unsigned STUCK_CYCLES = `XLT_STUCK_CYCLES
) (
    // clocks and reset
    input wire logic REF_CLK,
    input wire logic LINK_CLK,
    input wire logic RST,
    // control pins
    input wire logic ENABLE,
    input wire logic SUPPLY_LOCKOUT,
    input wire logic [3:0] LOWER_XLATE_CFG_INPUT,
    input wire logic [2:0] UPPER_XLATE_CFG_INPUT,
    input wire logic UPPER_XLATE_CFG_HIGH,
    output logic READY,
    // upstream bus
    input wire logic UPSTREAM_CLOCK_LINE_I,
    input wire logic UPSTREAM_DATA_LINE_I,
    // downstream bus
    input wire logic DOWNSTREAM_CLOCK_LINE_I,
    input wire logic DOWNSTREAM_DATA_LINE_I,
    output logic DOWNSTREAM_CLOCK_LINE_O,
    output logic DOWNSTREAM_CLOCK_LINE_OE,
    output logic DOWNSTREAM_DATA_LINE_O,
    output logic DOWNSTREAM_DATA_LINE_OE,
    // switches
    output logic BUS_CONNECT_SWITCH_A,
    output logic BUS_CONNECT_SWITCH_B,
    output logic AUXILIARY_SWITCH
);

    localparam int unsigned XLATE_CYCLES = `XLT_XLATE_CYCLES;
    localparam int unsigned STOPGEN_CYCLES = `XLT_STOPGEN_CYCLES;

    typedef struct packed {
        logic en_m;
        logic en_s;
        logic lock_m;
        logic lock_s;
        logic [6:0] cfg_m;
        logic [6:0] cfg_s;
        logic [3:0] bus_m;
        logic [3:0] bus_s;
        logic stop_m;
        logic stop_s;
        logic stop_p;
        xlt_pkg::xlt_ctl_state_t st;
        logic [6:0] xlate;
        logic [31:0] idle_cnt;
        logic ready;
    } xlt_ref_t;

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic conn_m;
        logic conn_s;
        logic pwr_m;
        logic pwr_s;
        logic pass_m;
        logic pass_s;
        logic [6:0] xl;
        logic xl_ok;
        xlt_pkg::xlt_link_state_t st;
        logic [3:0] fall_cnt;
        logic act;
        logic pend;
        logic [7:0] dly;
        logic [31:0] stuck_cnt;
        logic stop_tgl;
        logic sw;
        logic ds_oe;
        logic dsc_oe;
    } xlt_link_t;

    xlt_ref_t r_q;
    xlt_ref_t r_d;
    xlt_link_t l_q;
    xlt_link_t l_d;

    // control side
    always_comb begin
        logic off;
        logic stop_evt;
        logic bus_high;
        off = 1'b0;
        stop_evt = 1'b0;
        bus_high = 1'b0;
        r_d = r_q;
        r_d.en_m = ENABLE;
        r_d.en_s = r_q.en_m;
        r_d.lock_m = SUPPLY_LOCKOUT;
        r_d.lock_s = r_q.lock_m;
        r_d.cfg_m[`XLT_LOW_CFG_LSB +: 4] = LOWER_XLATE_CFG_INPUT;
        r_d.cfg_m[`XLT_HIGH_CFG_LSB +: 3] = UPPER_XLATE_CFG_INPUT;
        r_d.cfg_s = r_q.cfg_m;
        r_d.bus_m = {UPSTREAM_CLOCK_LINE_I, UPSTREAM_DATA_LINE_I,
                     DOWNSTREAM_CLOCK_LINE_I, DOWNSTREAM_DATA_LINE_I};
        r_d.bus_s = r_q.bus_m;
        r_d.stop_m = l_q.stop_tgl;
        r_d.stop_s = r_q.stop_m;
        r_d.stop_p = r_q.stop_s;
        off = !r_q.en_s || r_q.lock_s;
        stop_evt = r_q.stop_s != r_q.stop_p;
        bus_high = &r_q.bus_s;
        if (off) begin
            r_d.st = xlt_pkg::CTL_OFF;
            r_d.xlate = `XLT_XLATE_RESET;
            r_d.ready = 1'b0;
            r_d.idle_cnt = '0;
        end else begin
            unique case (r_q.st)
                xlt_pkg::CTL_OFF: begin
                    r_d.st = xlt_pkg::CTL_LOAD;
                end
                xlt_pkg::CTL_LOAD: begin
                    r_d.xlate = r_q.cfg_s;
                    r_d.idle_cnt = '0;
                    r_d.st = xlt_pkg::CTL_WAIT_IDLE;
                end
                xlt_pkg::CTL_WAIT_IDLE: begin
                    if (!bus_high) begin
                        r_d.idle_cnt = '0;
                    end else if (r_q.idle_cnt < IDLE_CYCLES) begin
                        r_d.idle_cnt = r_q.idle_cnt + 32'h1;
                    end
                    if (stop_evt || r_q.idle_cnt >= IDLE_CYCLES) begin
                        r_d.st = xlt_pkg::CTL_ON;
                        r_d.ready = 1'b1;
                    end
                end
                xlt_pkg::CTL_ON: begin
                    r_d.ready = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            r_q <= '{st: xlt_pkg::CTL_OFF, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    // bus side
    always_comb begin
        logic start;
        logic stop;
        logic fall;
        logic addr_phase;
        start = 1'b0;
        stop = 1'b0;
        fall = 1'b0;
        addr_phase = 1'b0;
        l_d = l_q;
        l_d.scl_m = UPSTREAM_CLOCK_LINE_I;
        l_d.scl_s = l_q.scl_m;
        l_d.scl_p = l_q.scl_s;
        l_d.sda_m = UPSTREAM_DATA_LINE_I;
        l_d.sda_s = l_q.sda_m;
        l_d.sda_p = l_q.sda_s;
        l_d.conn_m = r_q.ready;
        l_d.conn_s = l_q.conn_m;
        l_d.pwr_m = r_q.st != xlt_pkg::CTL_OFF;
        l_d.pwr_s = l_q.pwr_m;
        l_d.pass_m = UPPER_XLATE_CFG_HIGH;
        l_d.pass_s = l_q.pass_m;
        start = l_q.scl_s && l_q.scl_p && l_q.sda_p && !l_q.sda_s;
        stop = l_q.scl_s && l_q.scl_p && !l_q.sda_p && l_q.sda_s;
        fall = l_q.scl_p && !l_q.scl_s;
        addr_phase = l_q.st == xlt_pkg::LNK_ADDR || l_q.st == xlt_pkg::LNK_WAIT_STOP;
        // byte is held still by the control side while ready stands
        if (!l_q.conn_s) begin
            l_d.xl = `XLT_XLATE_RESET;
            l_d.xl_ok = 1'b0;
        end else if (!l_q.xl_ok) begin
            l_d.xl = r_q.xlate;
            l_d.xl_ok = 1'b1;
        end
        if (stop) begin
            l_d.stop_tgl = !l_q.stop_tgl;
        end
        if (l_q.st != xlt_pkg::LNK_ADDR || l_q.scl_s != l_q.scl_p) begin
            l_d.stuck_cnt = '0;
        end else if (l_q.stuck_cnt < STUCK_CYCLES) begin
            l_d.stuck_cnt = l_q.stuck_cnt + 32'h1;
        end
        if (l_q.pass_s || !l_q.pwr_s) begin
            l_d.st = xlt_pkg::LNK_IDLE;
            l_d.act = 1'b0;
            l_d.pend = 1'b0;
        end else if (addr_phase && stop) begin
            l_d.pend = 1'b0;
            l_d.dly = '0;
            if (l_q.act) begin
                l_d.st = xlt_pkg::LNK_STOP_GEN;
            end else begin
                l_d.st = xlt_pkg::LNK_IDLE;
            end
            l_d.act = 1'b0;
        end else begin
            unique case (l_q.st)
                xlt_pkg::LNK_IDLE: begin
                    if (start && l_q.conn_s) begin
                        l_d.st = xlt_pkg::LNK_ADDR;
                        l_d.fall_cnt = '0;
                        l_d.act = 1'b0;
                    end
                end
                xlt_pkg::LNK_ADDR: begin
                    if (start) begin
                        l_d.st = xlt_pkg::LNK_WAIT_STOP;
                        l_d.pend = 1'b0;
                    end else if (l_q.stuck_cnt >= STUCK_CYCLES) begin
                        l_d.st = xlt_pkg::LNK_DATA;
                        l_d.act = 1'b0;
                        l_d.pend = 1'b0;
                    end else if (fall) begin
                        l_d.fall_cnt = l_q.fall_cnt + 4'h1;
                        l_d.pend = 1'b1;
                        l_d.dly = '0;
                    end else if (l_q.pend) begin
                        l_d.dly = l_q.dly + 8'h1;
                        if (l_q.dly >= 8'(XLATE_CYCLES - 1)) begin
                            l_d.pend = 1'b0;
                            if (l_q.fall_cnt < 4'(`XLT_RW_FALL)) begin
                                l_d.act = l_q.xl[3'(`XLT_ADDR_BITS - l_q.fall_cnt)];
                            end else begin
                                l_d.act = 1'b0;
                            end
                            if (l_q.fall_cnt >= 4'(`XLT_DATA_FALL)) begin
                                l_d.st = xlt_pkg::LNK_DATA;
                            end
                        end
                    end
                end
                xlt_pkg::LNK_DATA: begin
                    l_d.act = 1'b0;
                    if (start && l_q.conn_s) begin
                        l_d.st = xlt_pkg::LNK_ADDR;
                        l_d.fall_cnt = '0;
                    end
                end
                xlt_pkg::LNK_WAIT_STOP: begin
                    l_d.pend = 1'b0;
                end
                xlt_pkg::LNK_STOP_GEN: begin
                    l_d.dly = l_q.dly + 8'h1;
                    if (l_q.dly >= 8'(2 * STOPGEN_CYCLES - 1)) begin
                        l_d.st = xlt_pkg::LNK_IDLE;
                        l_d.dly = '0;
                    end
                end
            endcase
        end
        l_d.sw = l_q.pwr_s && (l_q.conn_s || l_q.pass_s)
                 && l_d.st != xlt_pkg::LNK_STOP_GEN;
        // downstream data: xor during address byte, own stop when generating
        if (l_d.st == xlt_pkg::LNK_STOP_GEN) begin
            l_d.ds_oe = l_d.dly < 8'(STOPGEN_CYCLES);
        end else begin
            l_d.ds_oe = l_d.sw && !(l_q.sda_s ^ l_d.act);
        end
        l_d.dsc_oe = l_d.sw && !l_q.scl_s;
    end

    always_ff @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            l_q <= '{st: xlt_pkg::LNK_IDLE, default: '0};
        end else begin
            l_q <= l_d;
        end
    end

    // outputs
    assign READY = r_q.ready;
    assign BUS_CONNECT_SWITCH_A = l_q.sw;
    assign BUS_CONNECT_SWITCH_B = l_q.sw;
    assign AUXILIARY_SWITCH = l_q.sw;
    assign DOWNSTREAM_CLOCK_LINE_O = 1'b0;
    assign DOWNSTREAM_CLOCK_LINE_OE = l_q.dsc_oe;
    assign DOWNSTREAM_DATA_LINE_O = 1'b0;
    assign DOWNSTREAM_DATA_LINE_OE = l_q.ds_oe;

    // helper terms for the checks
    logic start_now;
    logic stop_now;
    assign start_now = l_q.scl_s && l_q.scl_p && l_q.sda_p && !l_q.sda_s;
    assign stop_now = l_q.scl_s && l_q.scl_p && !l_q.sda_p && l_q.sda_s;

    // checks
    chk_shutdown_ready: assert property (@(posedge REF_CLK) disable iff (RST)
        (!r_q.en_s || r_q.lock_s) |=> !READY && r_q.xlate == 7'h00)
        else $error("ready or byte kept during shutdown");

    chk_open_unready: assert property (@(posedge LINK_CLK) disable iff (RST)
        (!l_q.conn_s && !l_q.pass_s) |=> !BUS_CONNECT_SWITCH_A && !BUS_CONNECT_SWITCH_B)
        else $error("switches closed before connection");

    chk_ready_cause: assert property (@(posedge REF_CLK) disable iff (RST)
        $rose(READY) |-> $past(r_q.st) == xlt_pkg::CTL_WAIT_IDLE
            && ($past(r_q.idle_cnt) >= IDLE_CYCLES || $past(r_q.stop_s) != $past(r_q.stop_p)))
        else $error("ready raised without idle bus");

    chk_connect_ready: assert property (@(posedge LINK_CLK) disable iff (RST)
        (l_q.conn_s && l_q.pwr_s && l_q.st != xlt_pkg::LNK_STOP_GEN
            && l_d.st != xlt_pkg::LNK_STOP_GEN) |=> BUS_CONNECT_SWITCH_A)
        else $error("switch open while ready");

    chk_pass_closed: assert property (@(posedge LINK_CLK) disable iff (RST)
        (l_q.pass_s && l_q.pwr_s) |=> BUS_CONNECT_SWITCH_A && l_q.act == 1'b0)
        else $error("pass-through not closed");

    chk_pass_abort: assert property (@(posedge LINK_CLK) disable iff (RST)
        $rose(l_q.pass_s) |=> l_q.st == xlt_pkg::LNK_IDLE && !l_q.act)
        else $error("translation survived pass-through");

    chk_shift_clock_low: assert property (@(posedge LINK_CLK) disable iff (RST)
        (l_q.st == xlt_pkg::LNK_ADDR && $changed(l_q.act)) |-> !l_q.scl_s || $past(l_q.pass_s))
        else $error("translation bit changed with clock high");

    chk_stop_gen: assert property (@(posedge LINK_CLK) disable iff (RST)
        (l_q.st == xlt_pkg::LNK_STOP_GEN) |-> !BUS_CONNECT_SWITCH_A
            && (DOWNSTREAM_DATA_LINE_OE == (l_q.dly < 8'(STOPGEN_CYCLES))))
        else $error("stop not generated while disconnected");

    chk_stuck_abort: assert property (@(posedge LINK_CLK) disable iff (RST)
        (l_q.st == xlt_pkg::LNK_ADDR && l_q.stuck_cnt >= STUCK_CYCLES && !l_q.pass_s && l_q.pwr_s
            && !stop_now && !start_now) |=> l_q.st == xlt_pkg::LNK_DATA && !l_q.act)
        else $error("stuck clock not aborted");

    chk_data_plain: assert property (@(posedge LINK_CLK) disable iff (RST)
        (l_q.st == xlt_pkg::LNK_DATA) ##1 (l_q.st == xlt_pkg::LNK_DATA)
            |-> DOWNSTREAM_DATA_LINE_OE == (l_q.sw && !$past(l_q.sda_s)))
        else $error("data byte modified");

endmodule : xlt_translator

//--- tb/xlt_ds_slave.sv
/*
 * downstream bus model: pull-ups on both lines, open-drain drives of the
 * translator resolved into levels, capture of each byte seen by a slave.
 * assumes no slave pulls the lines, so acknowledge bits read high.
 */
`timescale 1ns/1ps
module xlt_ds_slave (
    // drives from the translator
    input wire logic scl_oe,
    input wire logic sda_oe,
    // resolved levels
    output logic scl,
    output logic sda,
    // observations
    output logic [7:0] last_byte,
    output int nstops
);
    logic prev_scl = 1'b1;
    logic prev_sda = 1'b1;
    logic [7:0] sh = 8'h00;
    int cnt = 0;

    // pull-ups win when released
    assign scl = ~scl_oe;
    assign sda = ~sda_oe;

    initial last_byte = 8'h00;
    initial nstops = 0;

    always @(scl or sda) begin
        if (scl && prev_scl && prev_sda && !sda) begin
            cnt = 0;
        end
        if (scl && prev_scl && !prev_sda && sda) begin
            nstops++;
        end
        // data taken only at a rising clock
        if (scl && !prev_scl) begin
            if (cnt < 8) begin
                sh = {sh[6:0], sda};
            end
            cnt++;
            if (cnt == 8) begin
                last_byte = sh;
            end
            if (cnt == 9) begin
                cnt = 0;
            end
        end
        prev_scl = scl;
        prev_sda = sda;
    end
endmodule : xlt_ds_slave

//--- tb/xlt_translator_tb.sv
/*
 * self-checking bench of the address translator: the bench is the upstream
 * master, xlt_ds_slave the downstream bus.
 * assumes shortened idle and stuck counts through the parameters.
 */
`timescale 1ns/1ps
module xlt_translator_tb;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic enable = 1'b0;
    logic lockout = 1'b0;
    logic [3:0] lo_cfg = 4'h0;
    logic [2:0] hi_cfg = 3'h0;
    logic pass_hi = 1'b0;
    logic up_scl = 1'b1;
    logic up_sda = 1'b1;
    logic ready, scl_oe, sda_oe, sw_a, sw_b, ds_scl, ds_sda;
    logic scl_o, sda_o, sw_x;
    logic [7:0] ds_byte;
    logic [6:0] xl, addr;
    logic [7:0] dat;
    int ds_nstops, n0;
    int err_total = 0;
    int num_checks = 0;
    int seed = 29;
    int cyc = 0;

    always #10 ref_clk = ~ref_clk;
    always #6 link_clk = ~link_clk;

    xlt_translator #(.IDLE_CYCLES(50), .STUCK_CYCLES(200)) DUT (
        .REF_CLK(ref_clk), .LINK_CLK(link_clk), .RST(rst),
        .ENABLE(enable), .SUPPLY_LOCKOUT(lockout),
        .LOWER_XLATE_CFG_INPUT(lo_cfg), .UPPER_XLATE_CFG_INPUT(hi_cfg),
        .UPPER_XLATE_CFG_HIGH(pass_hi), .READY(ready),
        .UPSTREAM_CLOCK_LINE_I(up_scl), .UPSTREAM_DATA_LINE_I(up_sda),
        .DOWNSTREAM_CLOCK_LINE_I(ds_scl), .DOWNSTREAM_DATA_LINE_I(ds_sda),
        .DOWNSTREAM_CLOCK_LINE_O(scl_o), .DOWNSTREAM_CLOCK_LINE_OE(scl_oe),
        .DOWNSTREAM_DATA_LINE_O(sda_o), .DOWNSTREAM_DATA_LINE_OE(sda_oe),
        .BUS_CONNECT_SWITCH_A(sw_a), .BUS_CONNECT_SWITCH_B(sw_b), .AUXILIARY_SWITCH(sw_x)
    );

    xlt_ds_slave slave (
        .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(ds_scl), .sda(ds_sda),
        .last_byte(ds_byte), .nstops(ds_nstops)
    );

    task test_done;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            test_done;
        end
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // expected downstream address byte: seven bits xor translation, r/w untouched
    function automatic logic [7:0] exp_addr(input logic [7:0] a, input logic [6:0] x);
        return {a[7:1] ^ x, a[0]};
    endfunction : exp_addr

    task wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wait_n

    // master: seven-bit addressing only, start/stop around each message or inside the address
    task start_cond;
        wait_n(10);
        up_sda = 1'b1;
        wait_n(10);
        up_scl = 1'b1;
        wait_n(20);
        up_sda = 1'b0;
        wait_n(20);
        up_scl = 1'b0;
    endtask : start_cond

    task send_bit(input logic b);
        wait_n(10);
        up_sda = b;
        wait_n(10);
        up_scl = 1'b1;
        wait_n(20);
        up_scl = 1'b0;
    endtask : send_bit

    task stop_cond;
        wait_n(10);
        up_sda = 1'b0;
        wait_n(10);
        up_scl = 1'b1;
        wait_n(20);
        up_sda = 1'b1;
        wait_n(40);
    endtask : stop_cond

    task send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i]);
        end
        send_bit(1'b1);
    endtask : send_byte

    // one message, r/w bit as given in the address byte; expected address byte worked out by the caller
    task message(input logic [7:0] a, input logic [7:0] d, input logic [7:0] ea);
        start_cond;
        send_byte(a);
        check(ds_byte, ea);
        send_byte(d);
        check(ds_byte, d);
        stop_cond;
    endtask : message

    task rand_msg;
        addr = 7'($random(seed));
        dat = 8'($random(seed));
        message({addr, dat[0]}, dat, exp_addr({addr, dat[0]}, xl));
    endtask : rand_msg

    task wait_conn;
        for (int k = 0; k < 400 && sw_a !== 1'b1; k++) begin
            wait_n(1);
        end
        check({7'h00, sw_a}, 8'h01);
    endtask : wait_conn

    task power_up(input logic [6:0] x);
        xl = x;
        lo_cfg = x[3:0];
        hi_cfg = x[6:4];
        enable = 1'b1;
        for (int k = 0; k < 400 && ready !== 1'b1; k++) begin
            wait_n(1);
        end
        check({7'h00, ready}, 8'h01);
        wait_conn;
        check({7'h00, sw_b}, 8'h01);
        check({6'h00, scl_o, sda_o}, 8'h00);
    endtask : power_up

    task chk_pass;
        wait_n(10);
        check({7'h00, sda_oe}, {7'h00, ~up_sda});
    endtask : chk_pass

    initial begin
        wait_n(10);
        rst = 1'b0;
        wait_n(30);
        check({6'h00, sw_a, ready}, 8'h00);
        power_up(7'($random(seed)));
        for (int j = 0; j < 4; j++) begin
            rand_msg;
        end
        lockout = 1'b1;
        wait_n(10);
        check({5'h00, sw_x, sw_a, ready}, 8'h00);
        lockout = 1'b0;
        enable = 1'b0;
        wait_n(10);
        check({5'h00, sw_x, sw_b, ready}, 8'h00);
        // repeated start on a translating 0 then on a 1
        for (int v = 0; v < 2; v++) begin
            enable = 1'b0;
            wait_n(10);
            power_up({1'b1, v[0], 5'($random(seed))});
            start_cond;
            send_bit(1'b0);
            n0 = ds_nstops;
            start_cond;
            check(8'(ds_nstops - n0), 8'(v));
            stop_cond;
            wait_conn;
            rand_msg;
        end
        // stop while the active bit is 1
        start_cond;
        n0 = ds_nstops;
        stop_cond;
        check({7'h00, sw_a}, 8'h00);
        wait_conn;
        check({7'h00, ds_nstops > n0}, 8'h01);
        rand_msg;
        // clock stuck low inside the address byte
        start_cond;
        send_bit(1'b1);
        wait_n(250);
        up_sda = 1'b0;
        chk_pass;
        up_sda = 1'b1;
        chk_pass;
        stop_cond;
        rand_msg;
        // pass-through raised mid-address, then a whole message
        start_cond;
        send_bit(1'b0);
        pass_hi = 1'b1;
        up_sda = 1'b1;
        chk_pass;
        up_sda = 1'b0;
        chk_pass;
        stop_cond;
        message(8'hA5, 8'h3C, 8'hA5);
        check({7'h00, sw_a}, 8'h01);
        pass_hi = 1'b0;
        wait_n(10);
        rand_msg;
        test_done;
    end
endmodule : xlt_translator_tb
